// ### rtl/lspv_regs.sv
// register bank: link status, phy tuning, product data capability over ahb-lite
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module lspv_regs (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire lspv_pkg::lspv_link_in_t link_in,
  input  wire logic                   pm_idle,
  output logic                        pm_power_down,
  input  wire logic                   ee_miso,
  output lspv_pkg::lspv_ee_out_t      ee_out,
  output logic [31:0]                 phy_train_cfg,
  output logic [31:0]                 phy_timer_cfg,
  output logic [31:0]                 phy_recovery_cfg
);
  import lspv_pkg::*;

  // ---------------- pin synchronisers ----------------
  lspv_link_in_t link_m_reg;
  lspv_link_in_t link_s_reg;
  logic          idle_m_reg;
  logic          idle_s_reg;
  logic          miso_m_reg;
  logic          miso_s_reg;
  // link taken as active in reset so the status bit reads 0 until the pin is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_m_reg <= '{1'b1, 1'b0, 1'b0, RST_LINK_WIDTH};
      link_s_reg <= '{1'b1, 1'b0, 1'b0, RST_LINK_WIDTH};
      idle_m_reg <= 1'b0;
      idle_s_reg <= 1'b0;
      miso_m_reg <= 1'b0;
      miso_s_reg <= 1'b0;
    end else begin
      link_m_reg <= link_in;
      link_s_reg <= link_m_reg;
      idle_m_reg <= pm_idle;
      idle_s_reg <= idle_m_reg;
      miso_m_reg <= ee_miso;
      miso_s_reg <= miso_m_reg;
    end
  end

  // ---------------- ahb-lite slave ----------------
  logic       wr_pend_reg;
  logic [7:0] wr_addr_reg;
  wire        take     = hsel && htrans[1] && hready;
  wire        word_acc = (hsize == 3'b010);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= take && hwrite && word_acc;
      if (take)
        wr_addr_reg <= haddr[7:0];
    end
  end

  wire wr_train   = wr_pend_reg && (wr_addr_reg == OFF_PHY_TRAIN);
  wire wr_timers  = wr_pend_reg && (wr_addr_reg == OFF_PWR_TIMERS);
  wire wr_recov   = wr_pend_reg && (wr_addr_reg == OFF_RECOVERY);
  wire wr_cap     = wr_pend_reg && (wr_addr_reg == OFF_PD_CAP);
  wire wr_data    = wr_pend_reg && (wr_addr_reg == OFF_PD_DATA);

  // ---------------- phy tuning registers ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_train_cfg    <= RST_PHY_TRAIN;
      phy_timer_cfg    <= RST_PWR_TIMERS;
      phy_recovery_cfg <= RST_RECOVERY;
    end else begin
      if (wr_train)
        phy_train_cfg <= hwdata;
      if (wr_timers)
        phy_timer_cfg <= hwdata;
      if (wr_recov)
        phy_recovery_cfg <= hwdata & MSK_RECOVERY;
    end
  end

  // ---------------- power-down wait ----------------
  logic [7:0] pd_cnt_reg;
  wire        pd_wait_en = phy_recovery_cfg[RC_PD_WAIT];
  wire        pd_expired = (pd_cnt_reg == 8'(PD_WAIT_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_cnt_reg    <= 8'h00;
      pm_power_down <= 1'b0;
    end else if (!idle_s_reg) begin
      pd_cnt_reg    <= 8'h00;
      pm_power_down <= 1'b0;
    end else begin
      if (!pd_expired)
        pd_cnt_reg <= pd_cnt_reg + 8'h01;
      // without the wait bit the entry is immediate
      pm_power_down <= !pd_wait_en || pd_expired;
    end
  end

  // ---------------- product data engine ----------------
  lspv_pd_state_t state_reg;
  logic [5:0]     pd_addr_reg;
  logic           pd_flag_reg;
  logic           pd_op_wr_reg;
  logic [31:0]    pd_data_reg;
  logic           ee_busy;
  logic           ee_done;
  logic [31:0]    ee_rx;
  logic           ee_cs_n_w;
  logic           ee_sck_w;
  logic           ee_mosi_w;

  wire        pd_idle   = (state_reg == PD_IDLE);
  // new operations while busy are dropped, software must poll the flag
  wire        pd_start  = wr_cap && pd_idle;
  wire        new_op_wr = hwdata[PD_FLAG_BIT];
  wire [7:0]  ee_loc    = {2'b00, pd_addr_reg} + PD_EE_BASE;
  wire [7:0]  start_loc = {2'b00, hwdata[PD_ADDR_LSB +: 6]} + PD_EE_BASE;
  wire [31:0] wr_bytes  = {pd_data_reg[7:0], pd_data_reg[15:8],
                           pd_data_reg[23:16], pd_data_reg[31:24]};
  wire [31:0] rd_bytes  = {ee_rx[7:0], ee_rx[15:8], ee_rx[23:16], ee_rx[31:24]};
  wire [EE_BITS-1:0] ee_tx = {new_op_wr ? EE_OP_WRITE : EE_OP_READ,
                              start_loc, wr_bytes};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= PD_IDLE;
      pd_addr_reg  <= RST_PD_ADDR;
      pd_flag_reg  <= RST_PD_FLAG;
      pd_op_wr_reg <= 1'b0;
    end else begin
      case (state_reg)
        PD_IDLE: begin
          if (pd_start) begin
            pd_addr_reg  <= hwdata[PD_ADDR_LSB +: 6];
            pd_flag_reg  <= new_op_wr;
            pd_op_wr_reg <= new_op_wr;
            state_reg    <= PD_RUN;
          end
        end
        PD_RUN: begin
          if (ee_done) begin
            pd_flag_reg <= !pd_op_wr_reg;
            state_reg   <= PD_IDLE;
          end
        end
        default: state_reg <= PD_IDLE;
      endcase
    end
  end

  // engine result beats a software write landing in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pd_data_reg <= RST_PD_DATA;
    else if (ee_done && !pd_op_wr_reg)
      pd_data_reg <= rd_bytes;
    else if (wr_data && pd_idle)
      pd_data_reg <= hwdata;
  end

  lspv_ee_shift u_shift (
    .clk    (hclk),
    .rst_n  (hresetn),
    .start  (pd_start),
    .tx     (ee_tx),
    .miso_s (miso_s_reg),
    .busy   (ee_busy),
    .done   (ee_done),
    .rx     (ee_rx),
    .cs_n   (ee_cs_n_w),
    .sck    (ee_sck_w),
    .mosi   (ee_mosi_w)
  );

  assign ee_out = '{cs_n: ee_cs_n_w, sck: ee_sck_w, mosi: ee_mosi_w};

  // ---------------- read path ----------------
  wire [31:0] link_word = {2'b00, ~link_s_reg.dl_active, SLOT_CLK_CFG,
                           link_s_reg.training, link_s_reg.train_err,
                           link_s_reg.width, LINK_SPEED_2G5, 16'h0000};
  wire [31:0] cap_word  = {pd_flag_reg, 7'h00, pd_addr_reg, 2'b00,
                           PD_NEXT_PTR, PD_CAP_ID};
  wire [7:0]  rd_off    = haddr[7:0];
  wire [31:0] rd_mux    = (rd_off == OFF_LINK_STATE) ? link_word :
                          (rd_off == OFF_PHY_TRAIN)  ? phy_train_cfg :
                          (rd_off == OFF_PWR_TIMERS) ? phy_timer_cfg :
                          (rd_off == OFF_RECOVERY)   ? phy_recovery_cfg :
                          (rd_off == OFF_PD_CAP)     ? cap_word :
                          (rd_off == OFF_PD_DATA)    ? pd_data_reg :
                                                       32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= rd_mux;
  end

  // ---------------- assertions ----------------
  a_link_speed: assert property (@(posedge hclk) disable iff (!hresetn)
    link_word[LS_SPEED_LSB +: 4] == 4'h1)
    else $error("link speed field not 1h");

  a_dl_active_low: assert property (@(posedge hclk) disable iff (!hresetn)
    link_in.dl_active [*3] |-> !link_word[LS_DL_BIT])
    else $error("link active bit high while link active");

  a_dl_inact_high: assert property (@(posedge hclk) disable iff (!hresetn)
    !link_in.dl_active [*3] |-> link_word[LS_DL_BIT])
    else $error("link active bit low while link inactive");

  a_recov_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_recov |=> $stable(phy_recovery_cfg[7:0]))
    else $error("recovery time changed without write");

  a_pd_wait_time: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(pm_power_down) && pd_wait_en |-> $past(pd_expired) && pd_cnt_reg == 8'h63)
    else $error("power-down entered before fixed wait");

  a_addr_stable: assert property (@(posedge hclk) disable iff (!hresetn)
    ee_busy |=> $stable(pd_addr_reg))
    else $error("word address moved during eeprom cycle");

  a_read_flag_low: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_start && !new_op_wr |=> !pd_flag_reg [*8])
    else $error("read flag not held at 0");

  a_read_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(pd_flag_reg) |-> $past(pd_start) || $past(ee_done && !pd_op_wr_reg))
    else $error("flag rose without cause");

  a_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
    ee_done && !pd_op_wr_reg |=> pd_data_reg == $past(rd_bytes))
    else $error("read data not loaded");

  a_write_flag_hi: assert property (@(posedge hclk) disable iff (!hresetn)
    !pd_start && !ee_done |=> $stable(pd_flag_reg))
    else $error("flag moved during eeprom cycle");

  a_cycle_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_start |-> ##[380:400] ee_done)
    else $error("eeprom cycle length wrong");

  a_write_flag_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    ee_done && pd_op_wr_reg |=> !pd_flag_reg)
    else $error("write flag not cleared");

  a_next_ptr: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_word[15:8] == 8'hF0 && cap_word[7:0] == 8'h03)
    else $error("capability pointer wrong");

  a_ee_location: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_start |-> ee_tx[39:32] == {2'b00, hwdata[23:18]} + 8'h40)
    else $error("eeprom location offset wrong");

  a_ignore_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cap && !pd_idle |=> $stable(pd_op_wr_reg))
    else $error("operation accepted while busy");

  a_speed_read: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && rd_off == OFF_LINK_STATE |=> hrdata[LS_SPEED_LSB +: 4] == 4'h1)
    else $error("link speed read back wrong");

  a_dl_read: assert property (@(posedge hclk) disable iff (!hresetn)
    link_in.dl_active [*3] ##0 (take && !hwrite && rd_off == OFF_LINK_STATE)
      |=> !hrdata[LS_DL_BIT])
    else $error("link active bit read back high");

  a_recov_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_recov |=> phy_recovery_cfg[7:0] == $past(hwdata[7:0]))
    else $error("recovery time not written");

  a_recov_rsvd: assert property (@(posedge hclk) disable iff (!hresetn)
    phy_recovery_cfg[31:24] == 8'h00)
    else $error("reserved recovery bits set");

  a_pd_no_early: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_wait_en && idle_s_reg && !pd_expired |=> !pm_power_down)
    else $error("power-down entered during wait");

  a_pd_leave: assert property (@(posedge hclk) disable iff (!hresetn)
    !idle_s_reg |=> !pm_power_down)
    else $error("power-down kept after idle dropped");

  a_addr_load: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_start |=> pd_addr_reg == $past(hwdata[PD_ADDR_LSB +: 6]))
    else $error("word address not loaded");

  a_frame_open: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_start |=> !ee_out.cs_n)
    else $error("eeprom cycle not started");

  a_frame_closed: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_idle |-> ee_out.cs_n && !ee_out.sck)
    else $error("eeprom selected while engine idle");

  a_loc_held: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_start |=> ee_loc == $past({2'b00, hwdata[PD_ADDR_LSB +: 6]}) + 8'h40)
    else $error("eeprom location not kept");

  a_data_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !ee_done && !wr_data |=> $stable(pd_data_reg))
    else $error("data register changed without cause");

  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus not ready or response not okay");

  c_read_cycle:  cover property (@(posedge hclk) disable iff (!hresetn)
    pd_start && !new_op_wr ##[1:400] ee_done);
  c_write_cycle: cover property (@(posedge hclk) disable iff (!hresetn)
    pd_start && new_op_wr ##[1:400] ee_done);
  c_power_down:  cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(pm_power_down));
  c_busy_write:  cover property (@(posedge hclk) disable iff (!hresetn)
    wr_cap && !pd_idle);
  c_link_down:   cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(link_word[LS_DL_BIT]));
endmodule
`default_nettype wire

// ### rtl/lspv_pkg.sv
// shared constants and carrier types for the link status / phy config / product data block
package lspv_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_LINK_STATE  = 8'hC0;
  localparam logic [7:0] OFF_PHY_TRAIN   = 8'hCC;
  localparam logic [7:0] OFF_PWR_TIMERS  = 8'hD0;
  localparam logic [7:0] OFF_RECOVERY    = 8'hD4;
  localparam logic [7:0] OFF_PD_CAP      = 8'hD8;
  localparam logic [7:0] OFF_PD_DATA     = 8'hEC;

  // reset values and writable masks
  localparam logic [31:0] RST_PHY_TRAIN  = 32'h0400_1060;
  localparam logic [31:0] RST_PWR_TIMERS = 32'h0400_0800;
  localparam logic [31:0] RST_RECOVERY   = 32'h0099_8254;
  localparam logic [31:0] MSK_RECOVERY   = 32'h00FF_FFFF;
  localparam logic [31:0] RST_PD_DATA    = 32'h0000_0000;
  localparam logic [5:0]  RST_PD_ADDR    = 6'h00;
  localparam logic        RST_PD_FLAG    = 1'b0;
  localparam logic [5:0]  RST_LINK_WIDTH = 6'h01;

  // fixed fields
  localparam logic [3:0]  LINK_SPEED_2G5 = 4'h1;
  localparam logic        SLOT_CLK_CFG   = 1'b1;
  localparam logic [7:0]  PD_CAP_ID      = 8'h03;
  localparam logic [7:0]  PD_NEXT_PTR    = 8'hF0;
  localparam logic [7:0]  PD_EE_BASE     = 8'h40;

  // field positions
  localparam int LS_SPEED_LSB = 16;
  localparam int LS_DL_BIT    = 29;
  localparam int RC_PD_WAIT   = 23;
  localparam int PD_ADDR_LSB  = 18;
  localparam int PD_FLAG_BIT  = 31;

  // serial eeprom framing
  localparam logic [7:0] EE_OP_READ  = 8'h03;
  localparam logic [7:0] EE_OP_WRITE = 8'h02;
  localparam int         EE_BITS     = 48;
  localparam int         EE_HALF     = 4;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PD_WAIT_NS    = 1000;
  localparam int PD_WAIT_CYC   = PD_WAIT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       dl_active;
    logic       training;
    logic       train_err;
    logic [5:0] width;
  } lspv_link_in_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } lspv_ee_out_t;

  typedef enum logic [1:0] {
    PD_IDLE = 2'b01,
    PD_RUN  = 2'b10
  } lspv_pd_state_t;

endpackage

// ### rtl/lspv_ee_shift.sv
// serial eeprom shift engine: one framed cycle of fixed length
`timescale 1ns/100ps
`default_nettype none
module lspv_ee_shift (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            start,
  input  wire logic [lspv_pkg::EE_BITS-1:0]    tx,
  input  wire logic                            miso_s,
  output logic                                 busy,
  output logic                                 done,
  output logic [31:0]                          rx,
  output logic                                 cs_n,
  output logic                                 sck,
  output logic                                 mosi
);
  import lspv_pkg::*;

  logic [EE_BITS-1:0] sh_reg;
  logic [5:0]         bit_reg;
  logic [2:0]         div_reg;
  wire                tick = (div_reg == 3'(EE_HALF - 1));
  wire                last = (bit_reg == 6'(EE_BITS - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      rx      <= 32'h0000_0000;
      cs_n    <= 1'b1;
      sck     <= 1'b0;
      mosi    <= 1'b0;
      sh_reg  <= '0;
      bit_reg <= 6'h00;
      div_reg <= 3'h0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy    <= 1'b1;
        cs_n    <= 1'b0;
        sh_reg  <= tx;
        mosi    <= tx[EE_BITS-1];
        bit_reg <= 6'h00;
        div_reg <= 3'h0;
      end else if (busy) begin
        div_reg <= tick ? 3'h0 : div_reg + 3'h1;
        if (tick && !sck) begin
          sck <= 1'b1;
          // miso is half a bit old here, well past its two-stage sync
          rx  <= {rx[30:0], miso_s};
        end else if (tick) begin
          sck <= 1'b0;
          if (last) begin
            busy <= 1'b0;
            cs_n <= 1'b1;
            done <= 1'b1;
          end else begin
            bit_reg <= bit_reg + 6'h01;
            sh_reg  <= {sh_reg[EE_BITS-2:0], 1'b0};
            mosi    <= sh_reg[EE_BITS-2];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/lspv_ee_model.sv
// behavioural serial eeprom holding the product data words
`timescale 1ns/100ps
`default_nettype none
module lspv_ee_model (
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso
);
  import lspv_pkg::*;
  logic [47:0] sh;
  logic [31:0] mem [0:255];
  logic [31:0] rd;
  logic [7:0]  op;
  logic [7:0]  loc;
  int          cnt;
  int          k;

  initial begin
    miso = 1'b0;
    cnt  = 0;
    for (int i = 0; i < 256; i++) mem[i] = {8'h5A, 8'(i), 8'(~i), 8'hC3};
  end

  always @(negedge cs_n) cnt = 0;

  always @(posedge sck) begin
    if (!cs_n) begin
      sh  = {sh[46:0], mosi};
      cnt = cnt + 1;
      if (cnt == 16) begin
        op  = sh[15:8];
        loc = sh[7:0];
        rd  = mem[sh[7:0]];
      end
    end
  end

  // reply low byte first, each byte msb first, changed on the falling edge
  always @(negedge sck) begin
    if (!cs_n && op == EE_OP_READ && cnt >= 16 && cnt < 48) begin
      k    = cnt - 16;
      miso = rd[8 * (k / 8) + 7 - (k % 8)];
    end
  end

  // released line shows the inverse so a stale bit is never taken as data
  always @(posedge cs_n) begin
    miso = ~miso;
    if (cnt == 48 && op == EE_OP_WRITE) begin
      mem[loc] = {sh[7:0], sh[15:8], sh[23:16], sh[31:24]};
    end
  end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the link status, phy config and product data registers
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import lspv_pkg::*;
  logic          hclk, hresetn, hsel, hwrite, hresp, hreadyout;
  logic          pm_idle, pm_power_down, ee_miso;
  logic [31:0]   haddr, hwdata, hrdata, rdata, train_cfg, timer_cfg, recov_cfg;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  lspv_link_in_t link_in;
  lspv_ee_out_t  ee_out;
  int            err_count, num_checks, n;

  lspv_regs i_lspv_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_in(link_in),
    .pm_idle(pm_idle), .pm_power_down(pm_power_down), .ee_miso(ee_miso), .ee_out(ee_out),
    .phy_train_cfg(train_cfg), .phy_timer_cfg(timer_cfg), .phy_recovery_cfg(recov_cfg));

  lspv_ee_model i_lspv_ee_model (.cs_n(ee_out.cs_n), .sck(ee_out.sck), .mosi(ee_out.mosi),
    .miso(ee_miso));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // the slave answers at once, but a stuck bus must still end
  task automatic edge_rdy();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 50) begin
      @(posedge hclk);
      k++;
    end
    if (k == 50) err_count++;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    edge_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    edge_rdy();
    rdata = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rdata, exp);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  function automatic logic [31:0] link_exp(input lspv_link_in_t l);
    return {2'b00, ~l.dl_active, 1'b1, l.training, l.train_err, l.width, 4'h1, 16'h0000};
  endfunction

  function automatic logic [31:0] ee_init(input logic [7:0] a);
    return {8'h5A, a, ~a, 8'hC3};
  endfunction

  task automatic poll(input logic done_val);
    int k;
    k = 0;
    ahb(1'b0, OFF_PD_CAP, 32'h0000_0000);
    while (rdata[31] !== done_val && k < 400) begin
      ahb(1'b0, OFF_PD_CAP, 32'h0000_0000);
      k++;
    end
    chk(32'(k < 400), 32'h0000_0001);
  endtask

  task automatic pd_read(input logic [5:0] a, input logic [31:0] exp);
    ahb(1'b1, OFF_PD_CAP, {8'h00, a, 18'h0_0000});
    rd_chk(OFF_PD_CAP, {8'h00, a, 2'b00, 16'hF003});
    poll(1'b1);
    rd_chk(OFF_PD_DATA, exp);
  endtask

  task automatic pd_time(input logic wait_bit, input int lo, input int hi);
    ahb(1'b1, OFF_RECOVERY, {8'h00, wait_bit, 23'h19_8254});
    pm_idle <= 1'b1;
    n = 0;
    while (pm_power_down !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
    pm_idle <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({31'h0000_0000, pm_power_down}, 32'h0000_0000);
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    end_of_test();
  end

  initial begin
    err_count  = 0;
    num_checks = 0;
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0000_0000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h0000_0000;
    pm_idle    = 1'b0;
    link_in    = '{1'b1, 1'b0, 1'b0, 6'h04};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rd_chk(OFF_PHY_TRAIN, 32'h0400_1060);
    rd_chk(OFF_PWR_TIMERS, 32'h0400_0800);
    rd_chk(OFF_RECOVERY, 32'h0099_8254);
    rd_chk(OFF_PD_CAP, 32'h0000_F003);
    rd_chk(OFF_PD_DATA, 32'h0000_0000);
    chk(recov_cfg, 32'h0099_8254);
    $display("test reset values done");

    rd_chk(OFF_LINK_STATE, link_exp(link_in));
    link_in <= '{1'b0, 1'b1, 1'b1, 6'h10};
    ahb(1'b1, OFF_LINK_STATE, 32'hFFFF_FFFF);
    rd_chk(OFF_LINK_STATE, link_exp(link_in));
    $display("test link status done");

    ahb(1'b1, OFF_PHY_TRAIN, 32'hFFFF_FFFF);
    ahb(1'b1, OFF_PWR_TIMERS, 32'hA5A5_5A5A);
    ahb(1'b1, OFF_RECOVERY, 32'hFFFF_FFFF);
    ahb(1'b1, 8'hC4, 32'hFFFF_FFFF);
    rd_chk(OFF_PHY_TRAIN, 32'hFFFF_FFFF);
    rd_chk(OFF_PWR_TIMERS, 32'hA5A5_5A5A);
    rd_chk(OFF_RECOVERY, 32'h00FF_FFFF);
    rd_chk(8'hC4, 32'h0000_0000);
    chk(train_cfg, 32'hFFFF_FFFF);
    chk(timer_cfg, 32'hA5A5_5A5A);
    $display("test register access done");

    pd_time(1'b1, 100, 105);
    pd_time(1'b0, 1, 5);
    $display("test power down done");

    ahb(1'b1, OFF_PD_DATA, 32'hCAFE_1234);
    ahb(1'b1, OFF_PD_CAP, {1'b1, 7'h00, 6'h2A, 18'h0_0000});
    rd_chk(OFF_PD_CAP, 32'h80A8_F003);
    // a second request while busy must be dropped whole
    ahb(1'b1, OFF_PD_CAP, 32'h0000_0000);
    poll(1'b0);
    rd_chk(OFF_PD_CAP, 32'h00A8_F003);
    chk(i_lspv_ee_model.mem[8'h6A], 32'hCAFE_1234);
    $display("test product data write done");

    pd_read(6'h3F, ee_init(8'h7F));
    pd_read(6'h00, ee_init(8'h40));
    pd_read(6'h2A, 32'hCAFE_1234);
    $display("test product data read done");
    end_of_test();
  end
endmodule
`default_nettype wire
